//--- core/sdc_pkg.sv
// Constants for the stepper driver serial control port
// Function
// - Configuration arrives only over shift clock, serial data and strobe.
// - Every transfer is 19 bits: one word select plus 18 data bits.
// - Select bit zero loads the data into the bridge current word.
// - Bits 1 to 6 are bridge one current code, bit 1 least significant.
// - Bits 7 to 12 are bridge two current code, bit 7 least significant.
// - A zero current code turns off all four drivers of that bridge.
// - Bit 13 sets bridge one direction: 1 drives A high, B low.
// - Bit 14 sets bridge two direction: 1 drives A high, B low.
// - Bits 15 and 16 pick decay per bridge: 0 mixed, 1 slow.
// - Bit 17 picks the reference: 0 internal 2 V, 1 external input.
// - Bit 18 picks the range divider: 0 divides by eight, 1 by four.
// - Select bit one loads the data into the timing word.
// - Converter level equals code plus one, times reference, over 64; code zero gives level zero.
// - Sleep low clears all serial control bits and disables everything.
// - Undervoltage lockout disables drivers and clears serial data.
package sdc_pkg;
  localparam int WORD_W = 19;
  localparam int DATA_W = 18;
  localparam int CODE_W = 6;
  localparam int LEVEL_W = 7;
  localparam int DIV_W = 4;
  localparam int SEL_POS = 0;
  localparam int B1_CODE_LO = 1;
  localparam int B2_CODE_LO = 7;
  localparam int B1_DIR_POS = 13;
  localparam int B2_DIR_POS = 14;
  localparam int B1_DECAY_POS = 15;
  localparam int B2_DECAY_POS = 16;
  localparam int REF_SEL_POS = 17;
  localparam int RANGE_POS = 18;
  localparam logic SEL_WORD0 = 1'h0;
  localparam logic [WORD_W-1:0] SHIFT_RST = 19'h00000;
  localparam logic [DATA_W-1:0] WORD_RST = 18'h00000;
  localparam logic [CODE_W-1:0] CODE_OFF = 6'h00;
  localparam logic [DIV_W-1:0] DIV_EIGHT = 4'h8;
  localparam logic [DIV_W-1:0] DIV_FOUR = 4'h4;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF = 7'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP = 7'h01;
  localparam int REF_FRACTION = 64;
endpackage

//--- core/sdc_top.sv
// Serial control port and first control word decode for two bridges
`timescale 1ns/1ps
`default_nettype none

// Two flip-flops per signal; nothing outside reads the first one
module sdc_sync_bit (
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Level from outside the clock domain
  input wire logic async_in,
  // Level after the second flip-flop
  output logic sync_out
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sdc_sync_t;

  sdc_sync_t sync_q;
  sdc_sync_t sync_d;

  always_comb begin
    sync_d = sync_q;
    sync_d.stage1 = async_in;
    sync_d.stage2 = sync_q.stage1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q.stage2;

endmodule

// Link domain: the host's own clock shifts the serial data in
module sdc_shifter (
  // Link clock and reset
  input wire logic sclk,
  input wire logic nrst,
  // Serial data, first bit ends at the top
  input wire logic sdata,
  // Last bits shifted
  output logic [sdc_pkg::WORD_W-1:0] shift_word
);

  typedef struct packed {
    logic [sdc_pkg::WORD_W-1:0] shift;
  } sdc_link_t;

  sdc_link_t link_q;
  sdc_link_t link_d;

  always_comb begin
    link_d = link_q;
    link_d.shift = {link_q.shift[sdc_pkg::WORD_W-2:0], sdata};
  end

  // Only nrst clears the shifter; sleep cannot reach a stopped clock
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      link_q <= '{shift: sdc_pkg::SHIFT_RST};
    end else begin
      link_q <= link_d;
    end
  end

  assign shift_word = link_q.shift;

endmodule

// Drivers and converter level of one bridge, both from flip-flops
module sdc_bridge (
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Next settings, taken in the cycle the word loads
  input wire logic [sdc_pkg::CODE_W-1:0] code_d,
  input wire logic dir_d,
  input wire logic off_d,
  // Drivers as {a_src, a_snk, b_src, b_snk}
  output logic [3:0] drive,
  // Level numerator over the reference fraction
  output logic [sdc_pkg::LEVEL_W-1:0] level
);

  typedef struct packed {
    logic [3:0] drv;
    logic [sdc_pkg::LEVEL_W-1:0] lvl;
  } sdc_bridge_t;

  sdc_bridge_t br_q;
  sdc_bridge_t br_d;

  // Either direction turns on one source and the opposite sink
  function automatic logic [3:0] sdc_drive(
    input logic [sdc_pkg::CODE_W-1:0] code,
    input logic dir,
    input logic off
  );
    logic [3:0] r;
    r = 4'h0;
    if (!off && code != sdc_pkg::CODE_OFF) begin
      if (dir) begin
        r = 4'h9;
      end else begin
        r = 4'h6;
      end
    end
    return r;
  endfunction

  // Code plus one, so code zero stays apart as off
  function automatic logic [sdc_pkg::LEVEL_W-1:0] sdc_level(
    input logic [sdc_pkg::CODE_W-1:0] code
  );
    logic [sdc_pkg::LEVEL_W-1:0] r;
    r = sdc_pkg::LEVEL_OFF;
    if (code != sdc_pkg::CODE_OFF) begin
      r = {1'b0, code} + sdc_pkg::LEVEL_STEP;
    end
    return r;
  endfunction

  always_comb begin
    br_d = br_q;
    br_d.drv = sdc_drive(code_d, dir_d, off_d);
    br_d.lvl = sdc_level(code_d);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      br_q <= '0;
    end else begin
      br_q <= br_d;
    end
  end

  assign drive = br_q.drv;
  assign level = br_q.lvl;

endmodule

module sdc_top (
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link from the host
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sstrobe,
  // Power state pins
  input wire logic sleep_n,
  input wire logic uvlo,
  // Bridge one drivers
  output logic bridge_one_output_a_src,
  output logic bridge_one_output_a_snk,
  output logic bridge_one_output_b_src,
  output logic bridge_one_output_b_snk,
  // Bridge two drivers
  output logic bridge_two_output_a_src,
  output logic bridge_two_output_a_snk,
  output logic bridge_two_output_b_src,
  output logic bridge_two_output_b_snk,
  // Converter settings
  output logic [sdc_pkg::CODE_W-1:0] bridge_one_code,
  output logic [sdc_pkg::CODE_W-1:0] bridge_two_code,
  output logic [sdc_pkg::LEVEL_W-1:0] bridge_one_level,
  output logic [sdc_pkg::LEVEL_W-1:0] bridge_two_level,
  output logic [1:0] slow_decay,
  output logic ref_external,
  output logic current_range_gain,
  output logic [sdc_pkg::DIV_W-1:0] range_divisor,
  // Raw control words
  output logic [sdc_pkg::DATA_W-1:0] bridge_current_control_word,
  output logic [sdc_pkg::DATA_W-1:0] timing_control_word
);

  // System domain state
  typedef struct packed {
    logic strb_prev;
    logic [sdc_pkg::DATA_W-1:0] word0;
    logic [sdc_pkg::DATA_W-1:0] word1;
  } sdc_sys_t;

  sdc_sys_t sys_q;
  sdc_sys_t sys_d;

  // Synchronised bits: strobe, sleep, lockout, then the link word
  logic [sdc_pkg::WORD_W+2:0] async_bus;
  logic [sdc_pkg::WORD_W+2:0] sync_bus;
  logic [sdc_pkg::WORD_W-1:0] shift_word;
  logic [sdc_pkg::WORD_W-1:0] w;
  logic strb_sync;
  logic awake_sync;
  logic lowv_sync;
  logic strobe_rise;
  logic held_off;
  logic [1:0][sdc_pkg::CODE_W-1:0] code_d;
  logic [1:0] dir_d;
  logic [1:0][3:0] drive;
  logic [1:0][sdc_pkg::LEVEL_W-1:0] level;

  sdc_shifter shifter_u (
    .sclk(sclk),
    .nrst(nrst),
    .sdata(sdata),
    .shift_word(shift_word)
  );

  // The host holds the word still from its last clock rise until
  // after the strobe is seen, so syncing each bit gives a whole word
  assign async_bus = {shift_word, uvlo, sleep_n, sstrobe};

  // The strobe, sleep and lockout pins and every word bit pass two flip-flops
  for (genvar i = 0; i < sdc_pkg::WORD_W + 3; i++) begin : g_sync
    sdc_sync_bit sync_u (
      .clk(clk),
      .nrst(nrst),
      .async_in(async_bus[i]),
      .sync_out(sync_bus[i])
    );
  end

  assign strb_sync = sync_bus[0];
  assign awake_sync = sync_bus[1];
  assign lowv_sync = sync_bus[2];
  assign w = sync_bus[sdc_pkg::WORD_W+2:3];
  assign strobe_rise = strb_sync && !sys_q.strb_prev;
  assign held_off = !awake_sync || lowv_sync;

  always_comb begin
    sys_d = sys_q;
    sys_d.strb_prev = strb_sync;
    // Clear wins over a strobe in the same cycle
    if (held_off) begin
      sys_d.word0 = sdc_pkg::WORD_RST;
      sys_d.word1 = sdc_pkg::WORD_RST;
    end else if (strobe_rise) begin
      if (w[sdc_pkg::SEL_POS] == sdc_pkg::SEL_WORD0) begin
        sys_d.word0 = w[sdc_pkg::WORD_W-1:1];
      end else begin
        sys_d.word1 = w[sdc_pkg::WORD_W-1:1];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  // Drivers and levels follow the next word, so they move with it
  assign code_d[0] =
    sys_d.word0[sdc_pkg::B1_CODE_LO-1 +: sdc_pkg::CODE_W];
  assign code_d[1] =
    sys_d.word0[sdc_pkg::B2_CODE_LO-1 +: sdc_pkg::CODE_W];
  assign dir_d[0] = sys_d.word0[sdc_pkg::B1_DIR_POS-1];
  assign dir_d[1] = sys_d.word0[sdc_pkg::B2_DIR_POS-1];

  // Both bridges decode alike
  for (genvar b = 0; b < 2; b++) begin : g_bridge
    sdc_bridge bridge_u (
      .clk(clk),
      .nrst(nrst),
      .code_d(code_d[b]),
      .dir_d(dir_d[b]),
      .off_d(held_off),
      .drive(drive[b]),
      .level(level[b])
    );
  end

  // Outputs straight from flip-flops, except range_divisor, decoded from the range bit
  assign bridge_one_output_a_src = drive[0][3];
  assign bridge_one_output_a_snk = drive[0][2];
  assign bridge_one_output_b_src = drive[0][1];
  assign bridge_one_output_b_snk = drive[0][0];
  assign bridge_two_output_a_src = drive[1][3];
  assign bridge_two_output_a_snk = drive[1][2];
  assign bridge_two_output_b_src = drive[1][1];
  assign bridge_two_output_b_snk = drive[1][0];
  assign bridge_one_code =
    sys_q.word0[sdc_pkg::B1_CODE_LO-1 +: sdc_pkg::CODE_W];
  assign bridge_two_code =
    sys_q.word0[sdc_pkg::B2_CODE_LO-1 +: sdc_pkg::CODE_W];
  assign bridge_one_level = level[0];
  assign bridge_two_level = level[1];
  assign slow_decay = {sys_q.word0[sdc_pkg::B2_DECAY_POS-1],
    sys_q.word0[sdc_pkg::B1_DECAY_POS-1]};
  assign ref_external = sys_q.word0[sdc_pkg::REF_SEL_POS-1];
  assign current_range_gain = sys_q.word0[sdc_pkg::RANGE_POS-1];
  assign range_divisor = current_range_gain ?
    sdc_pkg::DIV_FOUR : sdc_pkg::DIV_EIGHT;
  assign bridge_current_control_word = sys_q.word0;
  assign timing_control_word = sys_q.word1;

endmodule
`default_nettype wire

//--- tb/sdc_properties.sv
// Assertions on the serial control port outputs
`timescale 1ns/1ps
`default_nettype none
module sdc_properties (
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic nrst,
  input wire logic sstrobe,
  input wire logic sleep_n,
  input wire logic uvlo,
  // Observed outputs
  input wire logic bridge_one_output_a_src,
  input wire logic bridge_one_output_a_snk,
  input wire logic bridge_one_output_b_src,
  input wire logic bridge_one_output_b_snk,
  input wire logic [5:0] bridge_one_code,
  input wire logic [6:0] bridge_one_level,
  input wire logic current_range_gain,
  input wire logic [3:0] range_divisor,
  input wire logic [17:0] bridge_current_control_word,
  input wire logic [17:0] timing_control_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] drv;
  logic [17:0] w;
  assign drv = {bridge_one_output_a_src, bridge_one_output_a_snk,
    bridge_one_output_b_src, bridge_one_output_b_snk};
  assign w = bridge_current_control_word;
  // Sync flops delay sleep and lockout, so settle before judging
  sequence s_awake; (sleep_n && !uvlo) [*5]; endsequence
  sequence s_asleep; !sleep_n [*6]; endsequence
  sequence s_lowv; uvlo [*6]; endsequence
  sequence s_quiet; (!sstrobe && sleep_n && !uvlo) [*6]; endsequence
  property p_off; s_awake ##0 bridge_one_code == 6'h00 |-> drv == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("bridge on at code zero");
  property p_dir; s_awake ##0 bridge_one_code != 6'h00 |->
    drv == (w[12] ? 4'h9 : 4'h6); endproperty
  a_dir: assert property (p_dir) else $error("bad drive");
  property p_code; bridge_one_code == w[5:0]; endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_lvl; bridge_one_level == (bridge_one_code == 6'h00 ? 7'h00 :
    {1'h0, bridge_one_code} + 7'h01); endproperty
  a_lvl: assert property (p_lvl) else $error("bad level");
  property p_div; range_divisor == (current_range_gain ? 4'h4 : 4'h8) &&
    current_range_gain == w[17]; endproperty
  a_div: assert property (p_div) else $error("bad divisor");
  property p_sleep; s_asleep |-> w == 18'h00000 && drv == 4'h0; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep kept");
  property p_uvlo; s_lowv |-> w == 18'h00000 &&
    timing_control_word == 18'h00000; endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout kept");
  property p_hold; s_quiet |=> $stable(w) && $stable(timing_control_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved");
endmodule
`default_nettype wire

//--- tb/sdc_host.sv
// Host model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module sdc_host (
  // Serial link
  output logic sclk,
  output logic sdata,
  output logic sstrobe
);
  initial begin
    sclk = 1'h0;
    sdata = 1'h0;
    sstrobe = 1'h0;
  end
  // Clock stands low outside frames
  task automatic send(input logic [18:0] w);
    #7;
    for (int i = 18; i >= 0; i--) begin
      sdata = w[i];
      #40 sclk = 1'h1;
      #40 sclk = 1'h0;
    end
    sdata = ~sdata;
    sstrobe = 1'h1;
    #100 sstrobe = 1'h0;
    #50;
  endtask
endmodule
`default_nettype wire

//--- tb/sdc_top_tb.sv
// Bench for the stepper driver serial control port
`timescale 1ns/1ps
`default_nettype none
module sdc_top_tb;
  logic clk = 1'h0, nrst = 1'h0, sleep_n = 1'h1, uvlo = 1'h0;
  wire sclk, sdata, sstrobe;
  wire [3:0] d1, d2;
  logic [3:0] dv;
  logic [5:0] c1, c2;
  logic [6:0] l1, l2;
  logic [1:0] dec;
  logic rx, gn;
  logic [17:0] w0, w1;
  logic [18:0] q[$], e;
  logic [31:0] lf = 32'h11C5;
  int num_errors = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  sdc_host host_u (.sclk, .sdata, .sstrobe);
  sdc_top dut_u (.clk, .nrst, .sclk, .sdata, .sstrobe, .sleep_n, .uvlo,
    .bridge_one_output_a_src(d1[3]), .bridge_one_output_a_snk(d1[2]),
    .bridge_one_output_b_src(d1[1]), .bridge_one_output_b_snk(d1[0]),
    .bridge_two_output_a_src(d2[3]), .bridge_two_output_a_snk(d2[2]),
    .bridge_two_output_b_src(d2[1]), .bridge_two_output_b_snk(d2[0]),
    .bridge_one_code(c1), .bridge_two_code(c2), .bridge_one_level(l1),
    .bridge_two_level(l2), .slow_decay(dec), .ref_external(rx),
    .current_range_gain(gn), .range_divisor(dv),
    .bridge_current_control_word(w0), .timing_control_word(w1));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] lv(input logic [5:0] c);
    return c == 6'h00 ? 7'h00 : {1'h0, c} + 7'h01;
  endfunction
  function automatic logic [3:0] dr(input logic [5:0] c, input logic d);
    return c == 6'h00 ? 4'h0 : (d ? 4'h9 : 4'h6);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Refused words expect an all-zero result
  task automatic send(input logic [18:0] w, input logic ok);
    q.push_back(ok ? w : 19'h00000);
    host_u.send(w);
  endtask
  always begin
    @(posedge sstrobe);
    repeat (4) @(posedge clk);
    #1 e = q.pop_front();
    if (e[0]) chk(w1, e[18:1]);
    else begin
      chk(w0, e[18:1]);
      chk({c1, c2}, {e[6:1], e[12:7]});
      chk({d1, d2}, {dr(e[6:1], e[13]), dr(e[12:7], e[14])});
      chk({l1, l2}, {lv(e[6:1]), lv(e[12:7])});
      chk({dec, rx, gn, dv}, {e[16:15], e[17], e[18],
        e[18] ? 4'h4 : 4'h8});
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 nrst = 1'h1;
    send(19'h7FFFE, 1'h1);
    send(19'h7E000, 1'h1);
    send(19'h00003, 1'h1);
    for (int i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      send(lf[18:0], 1'h1);
    end
    @(posedge clk) #1 sleep_n = 1'h0;
    send(19'h7FFFE, 1'h0);
    @(posedge clk) #1 sleep_n = 1'h1;
    uvlo = 1'h1;
    send(19'h7FFFE, 1'h0);
    @(posedge clk) #1 uvlo = 1'h0;
    send(19'h2AAAA, 1'h1);
    #200 summarize();
  end
endmodule
bind sdc_top sdc_properties chk_u (.clk, .nrst, .sstrobe, .sleep_n, .uvlo,
  .bridge_one_output_a_src, .bridge_one_output_a_snk,
  .bridge_one_output_b_src, .bridge_one_output_b_snk, .bridge_one_code,
  .bridge_one_level, .current_range_gain, .range_divisor,
  .bridge_current_control_word, .timing_control_word);
`default_nettype wire
